// ==== rtl/adpf_defines.svh ====
// Constants for the shared address/data pin function and strap decode block.
`ifndef ADPF_DEFINES_SVH
`define ADPF_DEFINES_SVH
// Register map of the plain register port (word index = address).
`define ADPF_ADDR_SYS_CTRL 4'h0
`define ADPF_ADDR_PORTCTL 4'h1
`define ADPF_ADDR_FLAGOUT 4'h2
`define ADPF_ADDR_FLAGOE 4'h3
`define ADPF_ADDR_FLAGIN 4'h4
`define ADPF_ADDR_STRAPS 4'h5
`define ADPF_ADDR_PWRCTL 4'h6
// Field positions.
`define ADPF_SYS_CTRL_FLAGSEL_BIT 20
`define ADPF_PORTCTL_EN_BIT 0
`define ADPF_PORTCTL_W16_BIT 1
// Reset values.
`define ADPF_SYS_CTRL_RST 32'h0000_0000
`define ADPF_PORTCTL_RST 32'h0000_0000
`define ADPF_PWRCTL_RST 32'h0000_0000
// Strap codes.
`define ADPF_BOOT_SPI_SLAVE 2'h0
`define ADPF_BOOT_SPI_MASTER 2'h1
`define ADPF_BOOT_EPROM 2'h2
`define ADPF_CLK_3TO1 2'h0
`define ADPF_CLK_16TO1 2'h1
`define ADPF_CLK_8TO1 2'h2
`define ADPF_RATIO_3 5'h03
`define ADPF_RATIO_16 5'h10
`define ADPF_RATIO_8 5'h08
// PLL lock wait in input clock cycles.
`define ADPF_LOCK_CYCLES 4096
`endif

// ==== rtl/adpf_pkg.sv ====
// Types for the shared address/data pin function and strap decode block.
package adpf_pkg;
  typedef enum logic [1:0] {
    ADPF_BOOT_SLAVE,
    ADPF_BOOT_MASTER,
    ADPF_BOOT_PAR,
    ADPF_BOOT_RSVD
  } adpf_boot_e;
  typedef enum logic [1:0] {
    ADPF_ST_IDLE,
    ADPF_ST_LOCK,
    ADPF_ST_RUN
  } adpf_state_e;
  typedef struct packed {
    logic ale;
    logic data_phase;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic write;
  } adpf_port_req_s;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } adpf_pins_s;
endpackage

// ==== rtl/adpf_pin_function.sv ====
// Shared address/data pin function select, port phase muxing and strap decode.
// Functional notes
// [R1] Pins are flags only with control bit 20 set and parallel port disabled.
// [R2] Pins 0-7 carry flags 8-15; pins 8-15 carry flags 0-7.
// [R3] Boot straps: 00 SPI slave, 01 SPI master, 10 EPROM, 11 reserved.
// [R4] Clock straps: 00 ratio 3, 01 ratio 16, 10 ratio 8, 11 reserved.
// [R5] 8-bit, strobe high: low byte A15-8, high byte A23-16.
// [R6] 8-bit, strobe low: low byte D7-0, high byte A7-0.
// [R7] 16-bit, strobe high: low byte A7-0, high byte A15-8.
// [R8] 16-bit, strobe low: all pins carry D15-0, low byte low.
// [R9] Clock straps captured at reset; software may later change power control.
// [R10] After reset release wait 4096 input clocks before starting execution.
// [R11] External latch holds address bits from strobe phase through data phase.
`timescale 1ns/10ps
`default_nettype none
`include "adpf_defines.svh"
module adpf_pin_function
  import adpf_pkg::*;
#(
  parameter int LOCK_CYCLES = `ADPF_LOCK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire adpf_port_req_s port_req,
  output logic [15:0] port_rdata,
  input wire logic [1:0] boot_select_straps,
  input wire logic [1:0] clock_ratio_straps,
  input wire logic input_clock_pin,
  output logic ale,
  output logic [15:0] shared_addr_data_pins_o,
  output logic [15:0] shared_addr_data_pins_oe,
  input wire logic [15:0] shared_addr_data_pins_i,
  output logic [15:0] general_flag_pins_in,
  output logic core_run,
  output adpf_boot_e boot_mode,
  output logic [4:0] core_ratio,
  output logic ratio_reserved
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] system_control_reg_r, system_control_reg_nxt;
  logic [31:0] port_ctl_r, port_ctl_nxt;
  logic [15:0] flag_out_r, flag_out_nxt;
  logic [15:0] flag_oe_r, flag_oe_nxt;
  logic [31:0] power_mgmt_control_reg_r, power_mgmt_control_reg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] flag_in_r, flag_in_nxt;
  logic [15:0] port_rdata_r, port_rdata_nxt;
  logic [1:0] boot_r, boot_nxt;
  logic [1:0] ratio_code_r, ratio_code_nxt;
  logic straps_taken_r, straps_taken_nxt;
  adpf_state_e state_r, state_nxt;
  logic [12:0] lock_cnt_r, lock_cnt_nxt;
  logic iclk_q_r, iclk_q_nxt;
  adpf_pins_s pins_r, pins_nxt;
  logic ale_r, ale_nxt;
  logic flag_mode;
  logic w16;

  assign flag_mode = system_control_reg_r[`ADPF_SYS_CTRL_FLAGSEL_BIT] &&
                     !port_ctl_r[`ADPF_PORTCTL_EN_BIT]; // see [R1]
  assign w16 = port_ctl_r[`ADPF_PORTCTL_W16_BIT];

  // ------------------------------------------------------------
  // Register port and strap capture
  // ------------------------------------------------------------
  always_comb begin
    system_control_reg_nxt = system_control_reg_r;
    port_ctl_nxt = port_ctl_r;
    flag_out_nxt = flag_out_r;
    flag_oe_nxt = flag_oe_r;
    power_mgmt_control_reg_nxt = power_mgmt_control_reg_r;
    rdata_nxt = 32'h0000_0000;
    // Straps are sampled once on the first edge after release, never under reset.
    straps_taken_nxt = 1'b1;
    boot_nxt = straps_taken_r ? boot_r : boot_select_straps; // see [R3]
    ratio_code_nxt = straps_taken_r ? ratio_code_r : clock_ratio_straps; // see [R9]
    if (reg_wr) begin
      unique case (reg_addr)
        `ADPF_ADDR_SYS_CTRL: system_control_reg_nxt = reg_wdata;
        `ADPF_ADDR_PORTCTL: port_ctl_nxt = {30'h0000_0000, reg_wdata[1:0]};
        `ADPF_ADDR_FLAGOUT: flag_out_nxt = reg_wdata[15:0];
        `ADPF_ADDR_FLAGOE: flag_oe_nxt = reg_wdata[15:0];
        `ADPF_ADDR_PWRCTL: power_mgmt_control_reg_nxt = reg_wdata; // see [R9]
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ADPF_ADDR_SYS_CTRL: rdata_nxt = system_control_reg_r;
        `ADPF_ADDR_PORTCTL: rdata_nxt = port_ctl_r;
        `ADPF_ADDR_FLAGOUT: rdata_nxt = {16'h0000, flag_out_r};
        `ADPF_ADDR_FLAGOE: rdata_nxt = {16'h0000, flag_oe_r};
        `ADPF_ADDR_FLAGIN: rdata_nxt = {16'h0000, flag_in_r};
        `ADPF_ADDR_STRAPS: rdata_nxt = {25'h0000000, core_ratio, boot_r};
        `ADPF_ADDR_PWRCTL: rdata_nxt = power_mgmt_control_reg_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Strap decode
  // ------------------------------------------------------------
  always_comb begin
    boot_mode = adpf_boot_e'(boot_r); // see [R3]
    ratio_reserved = 1'b0;
    unique case (ratio_code_r) // see [R4]
      `ADPF_CLK_3TO1: core_ratio = `ADPF_RATIO_3;
      `ADPF_CLK_16TO1: core_ratio = `ADPF_RATIO_16;
      `ADPF_CLK_8TO1: core_ratio = `ADPF_RATIO_8;
      default: begin
        core_ratio = 5'h00;
        ratio_reserved = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // PLL lock wait, counted on input clock rising edges
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    lock_cnt_nxt = lock_cnt_r;
    iclk_q_nxt = input_clock_pin;
    unique case (state_r)
      ADPF_ST_IDLE: begin
        state_nxt = ADPF_ST_LOCK;
        lock_cnt_nxt = 13'h0000;
      end
      ADPF_ST_LOCK: begin
        if (input_clock_pin && !iclk_q_r) begin
          lock_cnt_nxt = lock_cnt_r + 13'h0001;
          if (lock_cnt_r == 13'(LOCK_CYCLES - 1)) begin
            state_nxt = ADPF_ST_RUN; // see [R10]
          end
        end
      end
      ADPF_ST_RUN: ;
      default: state_nxt = ADPF_ST_IDLE;
    endcase
  end
  assign core_run = (state_r == ADPF_ST_RUN);

  // ------------------------------------------------------------
  // Pin function mux
  // ------------------------------------------------------------
  always_comb begin
    pins_nxt.out = 16'h0000;
    pins_nxt.oe = 16'h0000;
    ale_nxt = 1'b0;
    flag_in_nxt = {shared_addr_data_pins_i[7:0], shared_addr_data_pins_i[15:8]}; // see [R2]
    port_rdata_nxt = port_rdata_r;
    if (flag_mode) begin
      // Flag n+8 sits on pin n, flag n on pin n+8.
      pins_nxt.out = {flag_out_r[7:0], flag_out_r[15:8]}; // see [R2]
      pins_nxt.oe = {flag_oe_r[7:0], flag_oe_r[15:8]}; // see [R2]
    end else if (port_ctl_r[`ADPF_PORTCTL_EN_BIT] && core_run) begin
      ale_nxt = port_req.ale;
      if (port_req.ale) begin
        pins_nxt.oe = 16'hFFFF;
        if (w16) begin
          pins_nxt.out = port_req.addr[15:0]; // see [R7]
        end else begin
          pins_nxt.out = port_req.addr[23:8]; // see [R5]
        end
      end else if (port_req.data_phase) begin
        if (w16) begin
          pins_nxt.out = port_req.wdata; // see [R8]
          pins_nxt.oe = port_req.write ? 16'hFFFF : 16'h0000;
          if (!port_req.write) begin
            port_rdata_nxt = shared_addr_data_pins_i; // see [R8]
          end
        end else begin
          // The high byte keeps the low address while the low byte moves data.
          pins_nxt.out = {port_req.addr[7:0], port_req.wdata[7:0]}; // see [R6]
          pins_nxt.oe = {8'hFF, port_req.write ? 8'hFF : 8'h00};
          if (!port_req.write) begin
            port_rdata_nxt = {8'h00, shared_addr_data_pins_i[7:0]}; // see [R6]
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      system_control_reg_r <= `ADPF_SYS_CTRL_RST;
      port_ctl_r <= `ADPF_PORTCTL_RST;
      flag_out_r <= 16'h0000;
      flag_oe_r <= 16'h0000;
      power_mgmt_control_reg_r <= `ADPF_PWRCTL_RST;
      rdata_r <= 32'h0000_0000;
      flag_in_r <= 16'h0000;
      port_rdata_r <= 16'h0000;
      boot_r <= 2'h0;
      ratio_code_r <= 2'h0;
      straps_taken_r <= 1'b0;
      state_r <= ADPF_ST_IDLE;
      lock_cnt_r <= 13'h0000;
      iclk_q_r <= 1'b0;
      pins_r <= '0;
      ale_r <= 1'b0;
    end else begin
      system_control_reg_r <= system_control_reg_nxt;
      port_ctl_r <= port_ctl_nxt;
      flag_out_r <= flag_out_nxt;
      flag_oe_r <= flag_oe_nxt;
      power_mgmt_control_reg_r <= power_mgmt_control_reg_nxt;
      rdata_r <= rdata_nxt;
      flag_in_r <= flag_in_nxt;
      port_rdata_r <= port_rdata_nxt;
      boot_r <= boot_nxt;
      ratio_code_r <= ratio_code_nxt;
      straps_taken_r <= straps_taken_nxt;
      state_r <= state_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      iclk_q_r <= iclk_q_nxt;
      pins_r <= pins_nxt;
      ale_r <= ale_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign port_rdata = port_rdata_r;
  assign shared_addr_data_pins_o = pins_r.out;
  assign shared_addr_data_pins_oe = pins_r.oe;
  assign ale = ale_r;
  assign general_flag_pins_in = flag_in_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_flag_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pins_r.oe != 16'h0000 && !ale_r) |-> $past(flag_mode) || $past(port_ctl_r[0])) // see [R1]
    else $error("pins driven outside flag or port use");
  chk_flag_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(flag_mode) |-> pins_r.out == {$past(flag_out_r[7:0]), $past(flag_out_r[15:8])}) // see [R2]
    else $error("flag to pin mapping wrong");
  chk_boot_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    straps_taken_r |=> $stable(boot_r)) // see [R3]
    else $error("boot strap changed after capture");
  chk_ratio_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ratio_code_r == 2'h1 |-> core_ratio == 5'h10) // see [R4]
    else $error("clock ratio decode wrong");
  chk_addr8_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ale_r && !$past(w16)) |-> pins_r.out == $past(port_req.addr[23:8])) // see [R5]
    else $error("8-bit address phase wrong");
  chk_data8_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(port_ctl_r[0] && core_run && !flag_mode && !port_req.ale && port_req.data_phase
      && !w16)) |-> pins_r.out[15:8] == $past(port_req.addr[7:0])) // see [R6]
    else $error("8-bit data phase high byte wrong");
  chk_addr16_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ale_r && $past(w16)) |-> pins_r.out == $past(port_req.addr[15:0])) // see [R7]
    else $error("16-bit address phase wrong");
  chk_lock_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(core_run) |-> lock_cnt_r == 13'(LOCK_CYCLES)) // see [R10]
    else $error("execution started before lock wait");
endmodule
`default_nettype wire

// ==== verification/adpf_ext_mem.sv ====
// External address latch and parallel read-only memory model for the shared pins.
`timescale 1ns/10ps
`default_nettype none
module adpf_ext_mem (
  input wire logic clk_sys,
  input wire logic w16,
  input wire logic ale,
  input wire logic [15:0] pins_o,
  input wire logic [15:0] pins_oe,
  output logic [23:0] latched,
  output logic [15:0] mem_o,
  output logic [15:0] mem_oe
);
  // ----------------------------------------------------------------
  // Latch and memory
  // ----------------------------------------------------------------
  logic [1:0] cnt = 2'h0;
  logic [23:0] full;
  always @(posedge clk_sys) begin
    if (ale) begin
      latched <= w16 ? {8'h00, pins_o} : {pins_o, 8'h00};
      cnt <= 2'h2;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end
  end
  assign full = w16 ? latched : {latched[23:8], pins_o[15:8]};
  // Drives only in a read data phase, so released lines fall back to the pull-ups.
  assign mem_oe = (!ale && cnt != 2'h0 && !pins_oe[0]) ? (w16 ? 16'hFFFF : 16'h00FF)
                  : 16'h0000;
  assign mem_o = full[15:0] ^ 16'h5A3C;
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the shared address/data pin function block.
`timescale 1ns/10ps
`default_nettype none
module testbench import adpf_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int LK = 8;
  logic clk_sys, rst_n, reg_wr, reg_rd, iclk, w16, ale, core_run, ratio_reserved;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, x, sv;
  logic [1:0] boot, rsel;
  logic [15:0] pins_o, pins_oe, pins_i, mem_o, mem_oe, ext_v, port_rdata, flags_in;
  logic [23:0] latched;
  logic [4:0] core_ratio;
  adpf_boot_e boot_mode;
  adpf_port_req_s port_req;
  int fails, n_compared, edges, i, j;
  // Lines nobody drives settle to the pull-up level held in ext_v.
  assign pins_i = (pins_oe & pins_o) | (~pins_oe & ((mem_oe & mem_o) | (~mem_oe & ext_v)));
  adpf_pin_function #(.LOCK_CYCLES(LK)) i_adpf_pin_function (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_req(port_req),
    .port_rdata(port_rdata), .boot_select_straps(boot), .clock_ratio_straps(rsel),
    .input_clock_pin(iclk), .ale(ale), .shared_addr_data_pins_o(pins_o),
    .shared_addr_data_pins_oe(pins_oe), .shared_addr_data_pins_i(pins_i),
    .general_flag_pins_in(flags_in), .core_run(core_run), .boot_mode(boot_mode),
    .core_ratio(core_ratio), .ratio_reserved(ratio_reserved));
  adpf_ext_mem i_adpf_ext_mem (.clk_sys(clk_sys), .w16(w16), .ale(ale), .pins_o(pins_o),
    .pins_oe(pins_oe), .latched(latched), .mem_o(mem_o), .mem_oe(mem_oe));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always begin
    repeat (2) @(posedge clk_sys);
    iclk <= ~iclk;
  end
  always @(posedge iclk or negedge rst_n) begin
    if (!rst_n) edges <= 0;
    else edges <= edges + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [4:0] rat(input logic [1:0] c);
    return c == 2'h0 ? 5'h03 : c == 2'h1 ? 5'h10 : c == 2'h2 ? 5'h08 : 5'h00;
  endfunction
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic do_reset(input logic [1:0] b, input logic [1:0] c);
    int k;
    @(posedge clk_sys) {rst_n, boot, rsel} <= {1'b0, b, c};
    repeat (8) @(posedge clk_sys);
    #1 chk(32'({pins_oe, ale, core_run}), 32'h0);
    @(posedge clk_sys) rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    {boot, rsel} <= {~b, ~c};
    k = 0;
    while (core_run !== 1'b1 && k < 200) begin
      @(posedge clk_sys) k++;
      #1;
    end
    if (core_run !== 1'b1) begin
      fails++;
      $display("[ERR] %0t lock wait timed out", $time);
      complete_run();
    end else begin
      chk(32'(edges >= LK && edges <= LK + 1), 32'h1);
    end
  endtask
  task automatic port_cyc(input logic w, input logic wr_en, input logic [23:0] a,
                          input logic [15:0] d);
    adpf_port_req_s r;
    logic [15:0] m;
    r = '{ale: 1'b1, data_phase: 1'b0, addr: a, wdata: d, write: wr_en};
    @(posedge clk_sys) port_req <= r;
    r.ale = 1'b0;
    r.data_phase = 1'b1;
    @(posedge clk_sys) port_req <= r;
    #1 chk({ale, pins_oe, pins_o}, {1'b1, 16'hFFFF, w ? a[15:0] : a[23:8]});
    m = wr_en ? 16'hFFFF : (w ? 16'h0000 : 16'hFF00);
    @(posedge clk_sys);
    #1 chk({ale, pins_oe, pins_o & m}, {1'b0, m, (w ? d : {a[7:0], d[7:0]}) & m});
    @(posedge clk_sys) port_req <= '0;
    repeat (2) @(posedge clk_sys);
    #1 chk(32'(latched), 32'(w ? {8'h00, a[15:0]} : {a[23:8], 8'h00}));
    if (!wr_en) chk(32'(port_rdata), 32'(w ? a[15:0] ^ 16'h5A3C : {8'h00, a[7:0] ^ 8'h3C}));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, iclk, w16, reg_addr, reg_wdata, boot, rsel} = '0;
    port_req = '0;
    ext_v = 16'hFFFF;
    fails = 0;
    n_compared = 0;
    void'($urandom(32'hE947F5A0));
    for (i = 0; i < 4; i++) begin
      do_reset(2'(i), 2'(3 - i));
      chk(32'(boot_mode), 32'(i));
      chk(32'({ratio_reserved, core_ratio}), 32'({i == 0, rat(2'(3 - i))}));
      sv = {25'h0, rat(2'(3 - i)), 2'(i)};
      rd(4'h5, x);
      chk(x, sv);
    end
    v = $urandom;
    wr(4'h6, v);
    wr(4'h5, 32'hFFFFFFFF);
    wr(4'hE, v);
    rd(4'h6, x);
    chk(x, v);
    rd(4'h5, x);
    chk(x, sv);
    rd(4'hE, x);
    chk(x, 32'h0);
    v = $urandom;
    wr(4'h0, 32'h00100000);
    wr(4'h2, v);
    wr(4'h3, 32'h0000FFFF);
    repeat (2) @(posedge clk_sys);
    #1 chk(32'({pins_oe, pins_o}), {16'hFFFF, v[7:0], v[15:8]});
    rd(4'h0, x);
    chk(x, 32'h00100000);
    wr(4'h1, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk(32'(pins_oe), 32'h0);
    wr(4'h1, 32'h0);
    wr(4'h3, 32'h0);
    ext_v <= 16'($urandom);
    repeat (3) @(posedge clk_sys);
    #1 chk(32'(flags_in), 32'({ext_v[7:0], ext_v[15:8]}));
    rd(4'h4, x);
    chk(x, 32'({ext_v[7:0], ext_v[15:8]}));
    ext_v <= 16'hFFFF;
    wr(4'h0, 32'h00100000);
    for (i = 0; i < 2; i++) begin
      w16 <= i[0];
      wr(4'h1, {30'h0, i[0], 1'b1});
      for (j = 0; j < 8; j++) begin
        port_cyc(i[0], j[0], j == 7 ? 24'hFFFFFF : 24'($urandom), 16'($urandom));
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
